/* File: verilog/twh_pkg.sv */
// Package: register map, field layout and timing of the two-wire byte access block
package twh_pkg;
	// ************************************************
	// Register map
	// ************************************************
	localparam logic [7:0] ADDR_DATA = 8'hb0;
	localparam logic [7:0] ADDR_WORD = 8'hb1;
	localparam logic [7:0] ADDR_TARGET = 8'hb2;
	localparam logic [7:0] ADDR_CTRL = 8'hb3;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [6:0] RESET_TARGET_ID = 7'h00;
	localparam int CTRL_FORM_BIT = 7;
	localparam int CTRL_BUSY_BIT = 5;
	localparam int CTRL_FAULT_BIT = 1;
	localparam int TGT_DIR_BIT = 0;
	localparam int TGT_ID_MSB = 7;
	localparam int TGT_ID_LSB = 1;
	// ************************************************
	// Link timing
	// ************************************************
	localparam int LINK_CLK_HZ = 8000000;
	localparam int SCL_HZ = 60000;
	localparam int QUARTER_CYCLES = LINK_CLK_HZ / (SCL_HZ * 4);
	localparam int QCNT_W = 6;
	localparam logic [QCNT_W-1:0] QUARTER_LAST = QCNT_W'(QUARTER_CYCLES - 1);
	localparam logic [QCNT_W-1:0] QCNT_ZERO = 6'h00;
	localparam logic [QCNT_W-1:0] QCNT_ONE = 6'h01;
	// ************************************************
	// Bit framing
	// ************************************************
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_STEP = 4'h1;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [1:0] Q_SETUP = 2'h0;
	localparam logic [1:0] Q_RISE = 2'h1;
	localparam logic [1:0] Q_HIGH = 2'h2;
	localparam logic [1:0] Q_FALL = 2'h3;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_TX, ST_RX, ST_STOP} twh_state_t;
	typedef enum logic [1:0] {SQ_ADDR, SQ_WORD, SQ_READDR, SQ_DATA} twh_seq_t;
endpackage : twh_pkg

/* File: verilog/twh_sync2.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module twh_sync2 (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Level
	input wire logic d_i,
	output logic q_o
);
	logic meta;
	logic next_meta;
	logic next_q;

	always_comb
	begin
		next_meta = d_i;
		next_q = meta;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			meta <= 1'b0;
			q_o <= 1'b0;
		end
		else
		begin
			meta <= next_meta;
			q_o <= next_q;
		end
	end
endmodule : twh_sync2

/* File: verilog/twh_tick.sv */
// Quarter-bit tick generator for the serial clock
`timescale 1ns/1ps
module twh_tick (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Tick
	output logic tick_o
);
	logic [twh_pkg::QCNT_W-1:0] cnt;
	logic [twh_pkg::QCNT_W-1:0] next_cnt;
	logic next_tick;

	// Four ticks per bit give about 60 kHz on the serial clock
	always_comb
	begin
		next_tick = (cnt == twh_pkg::QUARTER_LAST);
		next_cnt = next_tick ? twh_pkg::QCNT_ZERO : cnt + twh_pkg::QCNT_ONE;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cnt <= twh_pkg::QCNT_ZERO;
			tick_o <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			tick_o <= next_tick;
		end
	end

	property p_tick;
		@(posedge clk_i) disable iff (!reset_n_i)
		tick_o |=> !tick_o [*8];
	endproperty
	a_tick: assert property (p_tick) else $error("Tick spacing too short");
endmodule : twh_tick

/* File: verilog/twh_top.sv */
// Two-wire single-byte access engine with its configuration registers
// How it works
// - A read without error stores the received byte in the data register in the same cycle that busy clears.
// - Data and word address registers are cleared by cold reset only.
// - The word address register selects the byte inside the slave.
// - Writing the target register while busy is clear launches one transfer at once.
// - Target identifier is seven bits in the upper target bits, reset zero.
// - Lowest target bit picks write (zero) or read (one).
// - Request-in-flight is set while a launched transfer runs.
// - Bus fault flag is set on an error and cleared by reading it.
// - Addressing form zero sends identifier and word address, one only identifier.
// - Serial clock runs at about 60 kHz.
`timescale 1ns/1ps
module twh_top (
	// Core clock and resets
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic cold_reset_n_i,
	// Configuration register port
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	// Two-wire link
	input wire logic link_clk_i,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	// ************************************************
	// Core domain registers
	// ************************************************
	logic [7:0] data_byte, next_data_byte;
	logic [7:0] word_addr, next_word_addr;
	logic [7:0] target_dir, next_target_dir;
	logic form, next_form;
	logic busy, next_busy;
	logic fault, next_fault;
	logic start_tgl, next_start_tgl;
	logic done_prev, next_done_prev;
	logic [7:0] next_rdata;
	logic done_sync;
	logic done_evt;
	logic wr_idle;
	logic rd_ctrl;
	// Link domain state, read here only after the done toggle has crossed
	logic [7:0] rx_byte, next_rx_byte;
	logic err, next_err;
	logic done_tgl, next_done_tgl;

	assign done_evt = done_sync ^ done_prev;
	// Writes are ignored while busy so the link sees stable operands
	assign wr_idle = cfg_wr_i && !busy;
	assign rd_ctrl = cfg_rd_i && (cfg_addr_i == twh_pkg::ADDR_CTRL);

	twh_sync2 u_done_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.d_i(done_tgl),
		.q_o(done_sync)
	);

	always_comb
	begin
		next_target_dir = target_dir;
		next_form = form;
		next_busy = busy;
		next_fault = fault;
		next_start_tgl = start_tgl;
		next_done_prev = done_sync;
		next_rdata = cfg_rdata_o;
		if (wr_idle && cfg_addr_i == twh_pkg::ADDR_TARGET)
		begin
			next_target_dir = cfg_wdata_i;
			next_busy = 1'b1;
			next_start_tgl = ~start_tgl;
		end
		if (wr_idle && cfg_addr_i == twh_pkg::ADDR_CTRL)
			next_form = cfg_wdata_i[twh_pkg::CTRL_FORM_BIT];
		if (done_evt)
			next_busy = 1'b0;
		if (rd_ctrl)
			next_fault = 1'b0;
		if (done_evt && err)
			next_fault = 1'b1;
		if (cfg_rd_i)
		begin
			unique case (cfg_addr_i)
				twh_pkg::ADDR_DATA: next_rdata = data_byte;
				twh_pkg::ADDR_WORD: next_rdata = word_addr;
				twh_pkg::ADDR_TARGET: next_rdata = target_dir;
				twh_pkg::ADDR_CTRL: next_rdata = {form, 1'b0, busy, 3'b000, fault, 1'b0};
				default: next_rdata = twh_pkg::RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			target_dir <= {twh_pkg::RESET_TARGET_ID, 1'b0};
			form <= 1'b0;
			busy <= 1'b0;
			fault <= 1'b0;
			start_tgl <= 1'b0;
			done_prev <= 1'b0;
			cfg_rdata_o <= twh_pkg::RESET_BYTE;
		end
		else
		begin
			target_dir <= next_target_dir;
			form <= next_form;
			busy <= next_busy;
			fault <= next_fault;
			start_tgl <= next_start_tgl;
			done_prev <= next_done_prev;
			cfg_rdata_o <= next_rdata;
		end
	end

	// ************************************************
	// Cold-reset-only registers
	// ************************************************
	always_comb
	begin
		next_data_byte = data_byte;
		next_word_addr = word_addr;
		if (wr_idle && cfg_addr_i == twh_pkg::ADDR_DATA)
			next_data_byte = cfg_wdata_i;
		if (wr_idle && cfg_addr_i == twh_pkg::ADDR_WORD)
			next_word_addr = cfg_wdata_i;
		if (done_evt && target_dir[twh_pkg::TGT_DIR_BIT] && !err)
			next_data_byte = rx_byte;
	end

	always_ff @(posedge clk_i or negedge cold_reset_n_i)
	begin
		if (!cold_reset_n_i)
		begin
			data_byte <= twh_pkg::RESET_BYTE;
			word_addr <= twh_pkg::RESET_BYTE;
		end
		else
		begin
			data_byte <= next_data_byte;
			word_addr <= next_word_addr;
		end
	end

	// ************************************************
	// Link domain
	// ************************************************
	twh_pkg::twh_state_t state, next_state;
	twh_pkg::twh_seq_t seq, next_seq;
	logic [1:0] qph, next_qph;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shift, next_shift;
	logic scl_oe, next_scl_oe;
	logic sda_oe, next_sda_oe;
	logic start_prev, next_start_prev;
	logic start_sync;
	logic scl_in;
	logic sda_in;
	logic tick;
	logic at_ack;

	assign at_ack = (bit_cnt == twh_pkg::BIT_ACK);
	assign scl_oe_o = scl_oe;
	assign sda_oe_o = sda_oe;
	// Open drain: the pins only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	twh_sync2 u_start_sync (
		.clk_i(link_clk_i),
		.reset_n_i(reset_n_i),
		.d_i(start_tgl),
		.q_o(start_sync)
	);

	twh_sync2 u_scl_sync (
		.clk_i(link_clk_i),
		.reset_n_i(reset_n_i),
		.d_i(scl_i),
		.q_o(scl_in)
	);

	twh_sync2 u_sda_sync (
		.clk_i(link_clk_i),
		.reset_n_i(reset_n_i),
		.d_i(sda_i),
		.q_o(sda_in)
	);

	twh_tick u_tick (
		.clk_i(link_clk_i),
		.reset_n_i(reset_n_i),
		.tick_o(tick)
	);

	// Operands are core registers held still while busy
	function automatic logic [7:0] tx_byte(input twh_pkg::twh_seq_t s);
		unique case (s)
			twh_pkg::SQ_ADDR: tx_byte = {target_dir[twh_pkg::TGT_ID_MSB:twh_pkg::TGT_ID_LSB],
				target_dir[twh_pkg::TGT_DIR_BIT] & form};
			twh_pkg::SQ_WORD: tx_byte = word_addr;
			twh_pkg::SQ_READDR: tx_byte = {target_dir[twh_pkg::TGT_ID_MSB:twh_pkg::TGT_ID_LSB],
				1'b1};
			twh_pkg::SQ_DATA: tx_byte = data_byte;
		endcase
	endfunction : tx_byte

	always_comb
	begin
		next_state = state;
		next_seq = seq;
		next_qph = qph;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_scl_oe = scl_oe;
		next_sda_oe = sda_oe;
		next_rx_byte = rx_byte;
		next_err = err;
		next_done_tgl = done_tgl;
		next_start_prev = start_sync;
		if (state == twh_pkg::ST_IDLE)
		begin
			if (start_sync ^ start_prev)
			begin
				next_state = twh_pkg::ST_START;
				next_seq = twh_pkg::SQ_ADDR;
				next_qph = twh_pkg::Q_SETUP;
				next_err = 1'b0;
			end
		end
		else if (tick)
		begin
			next_qph = qph + 2'h1;
			unique case (qph)
				twh_pkg::Q_SETUP:
				begin
					if (state == twh_pkg::ST_STOP)
						next_sda_oe = 1'b1;
					else if (state == twh_pkg::ST_TX)
						next_sda_oe = !at_ack && !shift[7];
					else
						next_sda_oe = 1'b0;
				end
				twh_pkg::Q_RISE:
				begin
					next_scl_oe = 1'b0;
				end
				twh_pkg::Q_HIGH:
				begin
					// Slave may stretch the clock; looked at a quarter after release so
					// the synchroniser delay does not add a quarter to every bit
					if (!scl_in)
						next_qph = qph;
					else if (state == twh_pkg::ST_START)
						next_sda_oe = 1'b1;
					else if (state == twh_pkg::ST_STOP)
						next_sda_oe = 1'b0;
					else if (state == twh_pkg::ST_TX && at_ack && sda_in)
						next_err = 1'b1;
					else if (state == twh_pkg::ST_RX && !at_ack)
						next_shift = {shift[6:0], sda_in};
				end
				twh_pkg::Q_FALL:
				begin
					next_scl_oe = (state != twh_pkg::ST_STOP);
					next_bit_cnt = bit_cnt + twh_pkg::BIT_STEP;
					unique case (state)
						twh_pkg::ST_START:
						begin
							next_state = twh_pkg::ST_TX;
							next_bit_cnt = twh_pkg::BIT_FIRST;
							next_shift = tx_byte(seq);
						end
						twh_pkg::ST_TX:
						begin
							if (!at_ack)
								next_shift = {shift[6:0], 1'b0};
							else
							begin
								next_bit_cnt = twh_pkg::BIT_FIRST;
								next_state = twh_pkg::ST_TX;
								if (err)
									next_state = twh_pkg::ST_STOP;
								else if (seq == twh_pkg::SQ_ADDR && !form)
									next_seq = twh_pkg::SQ_WORD;
								else if (seq == twh_pkg::SQ_WORD && target_dir[twh_pkg::TGT_DIR_BIT])
								begin
									next_state = twh_pkg::ST_START;
									next_seq = twh_pkg::SQ_READDR;
								end
								else if (seq == twh_pkg::SQ_DATA)
									next_state = twh_pkg::ST_STOP;
								else
									next_seq = twh_pkg::SQ_DATA;
								if (!err && seq != twh_pkg::SQ_DATA && next_seq == twh_pkg::SQ_DATA
									&& target_dir[twh_pkg::TGT_DIR_BIT])
									next_state = twh_pkg::ST_RX;
								next_shift = tx_byte(next_seq);
							end
						end
						twh_pkg::ST_RX:
						begin
							// Ninth clock leaves data released as the closing no-acknowledge
							if (at_ack)
							begin
								next_rx_byte = shift;
								next_state = twh_pkg::ST_STOP;
							end
						end
						twh_pkg::ST_STOP:
						begin
							next_state = twh_pkg::ST_IDLE;
							next_done_tgl = ~done_tgl;
						end
						default: next_state = twh_pkg::ST_IDLE;
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state <= twh_pkg::ST_IDLE;
			seq <= twh_pkg::SQ_ADDR;
			qph <= twh_pkg::Q_SETUP;
			bit_cnt <= twh_pkg::BIT_FIRST;
			shift <= twh_pkg::RESET_BYTE;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			rx_byte <= twh_pkg::RESET_BYTE;
			err <= 1'b0;
			done_tgl <= 1'b0;
			start_prev <= 1'b0;
		end
		else
		begin
			state <= next_state;
			seq <= next_seq;
			qph <= next_qph;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			rx_byte <= next_rx_byte;
			err <= next_err;
			done_tgl <= next_done_tgl;
			start_prev <= next_start_prev;
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	property p_launch;
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_idle && cfg_addr_i == twh_pkg::ADDR_TARGET |=> busy && start_tgl != $past(start_tgl);
	endproperty
	a_launch: assert property (p_launch) else $error("Target write did not launch");

	property p_target;
		@(posedge clk_i) disable iff (!reset_n_i)
		wr_idle && cfg_addr_i == twh_pkg::ADDR_TARGET |=> target_dir == $past(cfg_wdata_i);
	endproperty
	a_target: assert property (p_target) else $error("Target and direction not stored");

	property p_busy_hold;
		@(posedge clk_i) disable iff (!reset_n_i)
		busy && !done_evt |=> busy;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("Busy dropped early");

	property p_fault_set;
		@(posedge clk_i) disable iff (!reset_n_i)
		done_evt && err |=> fault;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("Fault not flagged");

	property p_fault_clear;
		@(posedge clk_i) disable iff (!reset_n_i)
		rd_ctrl && !(done_evt && err) |=> !fault ##1 (!fault || $past(done_evt && err));
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("Fault not cleared");

	property p_rxdata;
		@(posedge clk_i) disable iff (!cold_reset_n_i || !reset_n_i)
		done_evt && target_dir[twh_pkg::TGT_DIR_BIT] && !err |=> data_byte == rx_byte && !busy;
	endproperty
	a_rxdata: assert property (p_rxdata) else $error("Read byte not stored");

	property p_nack;
		@(posedge link_clk_i) disable iff (!reset_n_i)
		state == twh_pkg::ST_TX && tick && qph == twh_pkg::Q_HIGH && at_ack && sda_in && scl_in
			|=> err ##[1:200] state == twh_pkg::ST_STOP;
	endproperty
	a_nack: assert property (p_nack) else $error("Missing acknowledge not handled");

	property p_word;
		@(posedge link_clk_i) disable iff (!reset_n_i)
		state == twh_pkg::ST_TX && tick && qph == twh_pkg::Q_FALL && at_ack && !err
			&& seq == twh_pkg::SQ_ADDR |=> form ? seq == twh_pkg::SQ_DATA : shift == word_addr;
	endproperty
	a_word: assert property (p_word) else $error("Wrong byte after identifier");
endmodule : twh_top

/* File: testbench/twh_eeprom_model.sv */
// Behavioural serial EEPROM on the two-wire link pins
`timescale 1ns/1ps
module twh_eeprom_model #(
	parameter logic [6:0] DEV_ID = 7'h50
) (
	// Resolved pin levels
	input wire logic scl_i,
	input wire logic sda_i,
	// High pulls SDA low
	output logic sda_pull_o
);
	logic [7:0] mem [256];
	logic [7:0] ptr = 8'h00;
	logic [7:0] sh = 8'h00;
	int bitn = 0;
	int byten = 0;
	bit act = 0;
	bit rd = 0;
	bit rdph = 0;
	initial sda_pull_o = 1'b0;
	// Start or repeated start rearms the byte count
	always @(negedge sda_i)
		if (scl_i === 1'b1)
		begin
			act = 1;
			rd = 0;
			rdph = 0;
			bitn = 0;
			byten = 0;
		end
	always @(posedge sda_i)
		if (scl_i === 1'b1)
			act = 0;
	// Sample on the rising clock, MSB first
	always @(posedge scl_i)
		if (act)
		begin
			if (!rdph)
				sh = {sh[6:0], sda_i};
			bitn++;
		end
	// Drive only while SCL is low
	always @(negedge scl_i)
		if (act)
		begin
			if (rdph && bitn < 8)
				sda_pull_o = ~sh[7 - bitn];
			else if (rdph)
			begin
				sda_pull_o = 1'b0;
				if (bitn == 9)
					act = 0;
			end
			else if (bitn == 8)
			begin
				sda_pull_o = (byten != 0) || (sh[7:1] == DEV_ID);
				rd = (byten == 0) && sh[0];
				if (byten == 1)
					ptr = sh;
				if (byten > 1)
				begin
					mem[ptr] = sh;
					ptr++;
				end
			end
			else if (bitn == 9)
			begin
				act = sda_pull_o;
				sda_pull_o = 1'b0;
				bitn = 0;
				byten++;
				if (rd && act)
				begin
					rdph = 1;
					sh = mem[ptr];
					ptr++;
					sda_pull_o = ~sh[7];
				end
			end
		end
endmodule : twh_eeprom_model

/* File: testbench/testbench.sv */
// Self-checking bench of the two-wire byte access block
`timescale 1ns/1ps
module testbench;
	localparam logic [6:0] ID = 7'h50;
	logic clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic cold_reset_n_i = 1'b0;
	logic cfg_wr_i = 1'b0;
	logic cfg_rd_i = 1'b0;
	logic [7:0] cfg_addr_i = 8'h00;
	logic [7:0] cfg_wdata_i = 8'h00;
	logic [7:0] cfg_rdata_o;
	logic scl_o;
	logic scl_oe_o;
	logic sda_o;
	logic sda_oe_o;
	logic sda_pull;
	logic [7:0] d;
	logic [7:0] w;
	logic [7:0] r;
	logic [7:0] s;
	int err_count = 0;
	int checks = 0;
	realtime t0 = 0;
	realtime t1 = 0;
	// Pull-ups on both wires
	wire logic scl = scl_oe_o ? 1'b0 : 1'b1;
	wire logic sda = (sda_oe_o | sda_pull) ? 1'b0 : 1'b1;
	initial forever #4 clk_i = ~clk_i;
	initial
	begin
		#3.3;
		forever #62.5 link_clk_i = ~link_clk_i;
	end
	always @(posedge scl)
	begin
		t0 = t1;
		t1 = $realtime;
	end
	twh_top u_twh_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .cold_reset_n_i(cold_reset_n_i),
		.cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .link_clk_i(link_clk_i),
		.scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o));
	twh_eeprom_model #(.DEV_ID(ID)) u_eeprom (.scl_i(scl), .sda_i(sda), .sda_pull_o(sda_pull));
	// ****************************************
	// Register access and comparison
	// ****************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_i);
		cfg_wr_i = 1'b1;
		cfg_addr_i = a;
		cfg_wdata_i = v;
		@(negedge clk_i);
		cfg_wr_i = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk_i);
		cfg_rd_i = 1'b1;
		cfg_addr_i = a;
		@(negedge clk_i);
		cfg_rd_i = 1'b0;
		v = cfg_rdata_o;
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] v;
		rd(a, v);
		check(v, exp, what);
	endtask : rdc
	// Polling clears the fault flag, so faults seen on the way are merged
	task automatic wait_idle(output logic [7:0] st);
		logic f;
		f = 1'b0;
		st = 8'hff;
		for (int n = 0; n < 600 && st[5] !== 1'b0; n++)
		begin
			repeat (256) @(negedge clk_i);
			rd(twh_pkg::ADDR_CTRL, st);
			f = f | st[1];
		end
		st[1] = f;
	endtask : wait_idle
	task automatic hold_reset();
		@(negedge clk_i);
		reset_n_i = 1'b0;
		repeat (2) @(posedge link_clk_i);
		@(negedge clk_i);
		reset_n_i = 1'b1;
		cold_reset_n_i = 1'b1;
		repeat (2) @(negedge clk_i);
	endtask : hold_reset
	task automatic end_of_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	initial
	begin
		#3000000;
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		end_of_test();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		void'($urandom(32'ha7aa4a15));
		d = 8'($urandom);
		w = 8'($urandom);
		r = 8'($urandom);
		// Read byte must differ from the data register it lands in
		if (r == ~d)
			r = d;
		hold_reset();
		for (int a = 0; a < 4; a++)
			rdc(8'hb0 + 8'(a), 8'h00, "reset value");
		rdc(8'hc0, 8'h00, "unmapped read");
		wr(twh_pkg::ADDR_DATA, d);
		wr(twh_pkg::ADDR_WORD, w);
		wr(twh_pkg::ADDR_TARGET, {ID, 1'b0});
		rdc(twh_pkg::ADDR_CTRL, 8'h20, "busy after launch");
		wr(twh_pkg::ADDR_WORD, ~w);
		wait_idle(s);
		check(s, 8'h00, "status after write");
		check(u_eeprom.mem[w], d, "byte at word address");
		rdc(twh_pkg::ADDR_WORD, w, "word address kept");
		checks++;
		if (t1 - t0 < 16400 || t1 - t0 > 16600)
		begin
			err_count++;
			$display("Error at %0t: serial bit period %0t", $time, t1 - t0);
		end
		// Word-addressed read goes through the repeated start
		u_eeprom.mem[w] = ~d;
		wr(twh_pkg::ADDR_TARGET, {ID, 1'b1});
		wait_idle(s);
		check(s, 8'h00, "status after word read");
		rdc(twh_pkg::ADDR_DATA, ~d, "byte read at word address");
		hold_reset();
		rdc(twh_pkg::ADDR_DATA, ~d, "data after warm reset");
		rdc(twh_pkg::ADDR_WORD, w, "word after warm reset");
		rdc(twh_pkg::ADDR_TARGET, 8'h00, "target after warm reset");
		u_eeprom.mem[8'(w + 8'h01)] = r;
		wr(twh_pkg::ADDR_CTRL, 8'h80);
		rdc(twh_pkg::ADDR_CTRL, 8'h80, "form select");
		wr(twh_pkg::ADDR_TARGET, {ID, 1'b1});
		wait_idle(s);
		check(s, 8'h80, "status after read");
		rdc(twh_pkg::ADDR_DATA, r, "byte read");
		rdc(twh_pkg::ADDR_TARGET, {ID, 1'b1}, "target field");
		wr(twh_pkg::ADDR_TARGET, {ID ^ 7'h01, 1'b0});
		wait_idle(s);
		check(s, 8'h82, "fault on missing acknowledge");
		rdc(twh_pkg::ADDR_CTRL, 8'h80, "fault cleared by read");
		rdc(twh_pkg::ADDR_DATA, r, "data kept on fault");
		check({6'h00, scl_o, sda_o}, 8'h00, "open drain pin levels");
		end_of_test();
	end
endmodule : testbench
